// File: common/tifr_pkg.sv
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package tifr_pkg;
  // ----------------------------------------------------------------
  // Command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_OT_FAULT_THR = 8'h4f;
  localparam logic [7:0] CMD_OT_ACTION = 8'h50;
  localparam logic [7:0] CMD_OT_WARN_THR = 8'h51;
  localparam logic [7:0] CMD_UT_WARN_THR = 8'h52;
  localparam logic [7:0] CMD_UT_FAULT_THR = 8'h53;
  localparam logic [7:0] CMD_UT_ACTION = 8'h54;
  localparam logic [7:0] CMD_VIN_OV_THR = 8'h55;
  // ----------------------------------------------------------------
  // Reset values (action bytes; thresholds in degrees C, two's complement, or volts)
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_OT_ACTION = 8'h80;
  localparam logic [7:0] RST_UT_ACTION = 8'hb8;
  localparam logic [15:0] RST_OT_FAULT_THR = 16'h006e;
  localparam logic [15:0] RST_OT_WARN_THR = 16'h0064;
  localparam logic [15:0] RST_UT_WARN_THR = 16'hffd8;
  localparam logic [15:0] RST_UT_FAULT_THR = 16'hffd3;
  localparam logic [15:0] RST_VIN_OV_THR = 16'h010e;
  // ----------------------------------------------------------------
  // Action byte fields
  // ----------------------------------------------------------------
  localparam int MODE_HI = 7;
  localparam int MODE_LO = 6;
  localparam int RSTRT_HI = 5;
  localparam int RSTRT_LO = 3;
  localparam logic [1:0] MODE_CONT = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [2:0] RSTRT_LATCH = 3'h0;
  localparam logic [2:0] RSTRT_ENDLESS = 3'h7;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 125_000_000;
  localparam longint RECOV_S = 5;
  localparam longint CLEAR_S = 30;
  localparam longint RECOV_CYC = RECOV_S * CLK_HZ;
  localparam longint CLEAR_CYC = CLEAR_S * CLK_HZ;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ot_warn;
    logic ut_warn;
    logic ot_fault;
    logic ut_fault;
    logic vin_ov;
  } tifr_alarm_t;
  typedef enum logic [1:0] {ST_RUN, ST_RECOVER, ST_LATCHED, ST_OFF} tifr_state_t;
endpackage : tifr_pkg

// File: core/tifr_core.sv
`timescale 1ns/1ns
module tifr_core #(
  parameter logic [31:0] P_RECOV_CYC = 32'(tifr_pkg::RECOV_CYC),
  parameter logic [31:0] P_CLEAR_CYC = 32'(tifr_pkg::CLEAR_CYC)
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_wr_req,
  input wire logic [15:0] i_wr_data,
  input wire logic i_rd_req,
  input wire logic signed [15:0] i_temp,
  input wire logic [15:0] i_vin,
  input wire logic i_off_req,
  output logic [15:0] o_rd_data,
  output logic o_ack,
  output logic o_nak,
  output tifr_pkg::tifr_alarm_t o_alarm,
  output logic o_out_en,
  output logic o_latched,
  output logic [2:0] o_restart_cnt
);
  import tifr_pkg::*;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [7:0] ot_action;
  logic [7:0] ut_action;
  logic [15:0] ot_fault_thr;
  logic [15:0] ot_warn_thr;
  logic [15:0] ut_warn_thr;
  logic [15:0] ut_fault_thr;
  logic [15:0] vin_ov_thr;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire hit_ot_fault_thr = (i_cmd_code == CMD_OT_FAULT_THR);
  wire hit_ot_action = (i_cmd_code == CMD_OT_ACTION);
  wire hit_ot_warn_thr = (i_cmd_code == CMD_OT_WARN_THR);
  wire hit_ut_warn_thr = (i_cmd_code == CMD_UT_WARN_THR);
  wire hit_ut_fault_thr = (i_cmd_code == CMD_UT_FAULT_THR);
  wire hit_ut_action = (i_cmd_code == CMD_UT_ACTION);
  wire hit_vin_ov_thr = (i_cmd_code == CMD_VIN_OV_THR);
  wire hit_any = hit_ot_fault_thr | hit_ot_action | hit_ot_warn_thr |
                 hit_ut_warn_thr | hit_ut_fault_thr | hit_ut_action |
                 hit_vin_ov_thr;
  wire access = i_wr_req | i_rd_req;

  // Unsupported action values are dropped so the old setting stays
  // visible on read-back.
  wire [1:0] wr_mode = i_wr_data[MODE_HI:MODE_LO];
  wire [2:0] wr_rstrt = i_wr_data[RSTRT_HI:RSTRT_LO];
  wire ot_action_ok = (wr_mode == MODE_STOP);
  wire ut_action_ok = (wr_mode == MODE_CONT) |
                      ((wr_mode == MODE_STOP) & (wr_rstrt == RSTRT_ENDLESS));
  wire wr_ot_action = i_wr_req & hit_ot_action & ot_action_ok;
  wire wr_ut_action = i_wr_req & hit_ut_action & ut_action_ok;

  logic [15:0] rd_mux;
  always_comb begin
    if (hit_ot_fault_thr) begin
      rd_mux = ot_fault_thr;
    end else if (hit_ot_action) begin
      rd_mux = {8'h00, ot_action};
    end else if (hit_ot_warn_thr) begin
      rd_mux = ot_warn_thr;
    end else if (hit_ut_warn_thr) begin
      rd_mux = ut_warn_thr;
    end else if (hit_ut_fault_thr) begin
      rd_mux = ut_fault_thr;
    end else if (hit_ut_action) begin
      rd_mux = {8'h00, ut_action};
    end else if (hit_vin_ov_thr) begin
      rd_mux = vin_ov_thr;
    end else begin
      rd_mux = 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ot_action <= RST_OT_ACTION;
      ut_action <= RST_UT_ACTION;
    end else if (i_clk_en) begin
      if (wr_ot_action) begin
        ot_action <= i_wr_data[7:0];
      end
      if (wr_ut_action) begin
        ut_action <= i_wr_data[7:0];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      ot_fault_thr <= RST_OT_FAULT_THR;
      ot_warn_thr <= RST_OT_WARN_THR;
      ut_warn_thr <= RST_UT_WARN_THR;
      ut_fault_thr <= RST_UT_FAULT_THR;
      vin_ov_thr <= RST_VIN_OV_THR;
    end else if (i_clk_en && i_wr_req) begin
      if (hit_ot_fault_thr) begin
        ot_fault_thr <= i_wr_data;
      end
      if (hit_ot_warn_thr) begin
        ot_warn_thr <= i_wr_data;
      end
      if (hit_ut_warn_thr) begin
        ut_warn_thr <= i_wr_data;
      end
      if (hit_ut_fault_thr) begin
        ut_fault_thr <= i_wr_data;
      end
      if (hit_vin_ov_thr) begin
        vin_ov_thr <= i_wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Command answer
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 16'h0000;
      o_ack <= 1'b0;
      o_nak <= 1'b0;
    end else if (i_clk_en) begin
      o_ack <= access & hit_any;
      o_nak <= access & ~hit_any;
      if (i_rd_req) begin
        o_rd_data <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Comparators
  // ----------------------------------------------------------------
  wire ot_warn_now = i_temp > $signed(ot_warn_thr);
  wire ut_warn_now = i_temp < $signed(ut_warn_thr);
  wire ot_fault_now = i_temp > $signed(ot_fault_thr);
  wire ut_fault_now = i_temp < $signed(ut_fault_thr);
  wire vin_ov_now = i_vin > vin_ov_thr;

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_alarm <= '0;
    end else if (i_clk_en) begin
      o_alarm.ot_warn <= ot_warn_now;
      o_alarm.ut_warn <= ut_warn_now;
      o_alarm.ot_fault <= ot_fault_now;
      o_alarm.ut_fault <= ut_fault_now;
      o_alarm.vin_ov <= vin_ov_now;
    end
  end

  // ----------------------------------------------------------------
  // Fault response
  // ----------------------------------------------------------------
  wire [1:0] ot_mode = ot_action[MODE_HI:MODE_LO];
  wire [2:0] ot_rstrt = ot_action[RSTRT_HI:RSTRT_LO];
  wire [1:0] ut_mode = ut_action[MODE_HI:MODE_LO];
  // Mode 00 on the cold side leaves the output running.
  wire ut_stops = ut_fault_now & (ut_mode == MODE_STOP);
  wire ot_stops = ot_fault_now & (ot_mode == MODE_STOP);
  wire any_stop = ot_stops | ut_stops;

  tifr_state_t state;
  tifr_state_t next_state;
  logic [2:0] restart_cnt;
  logic [2:0] next_restart_cnt;
  logic [31:0] timer;
  logic [31:0] next_timer;

  // Only the hot side carries a bounded count; the cold side is
  // always endless once accepted.
  wire ot_latch_now = (ot_rstrt == RSTRT_LATCH) |
                      ((ot_rstrt != RSTRT_ENDLESS) & (restart_cnt >= ot_rstrt));
  wire latch_now = ot_stops & ot_latch_now;
  wire recov_done = (timer >= P_RECOV_CYC - 32'd1);
  wire clear_done = (timer >= P_CLEAR_CYC - 32'd1);
  wire cnt_full = (restart_cnt == RSTRT_ENDLESS);

  always_comb begin
    next_state = state;
    next_restart_cnt = restart_cnt;
    next_timer = timer;
    case (state)
      ST_RUN: begin
        if (i_off_req) begin
          next_state = ST_OFF;
        end else if (latch_now) begin
          next_state = ST_LATCHED;
        end else if (any_stop) begin
          next_state = ST_RECOVER;
          next_timer = 32'd0;
          if (!cnt_full) begin
            next_restart_cnt = restart_cnt + 3'd1;
          end
        end else if (restart_cnt != 3'd0) begin
          if (clear_done) begin
            next_restart_cnt = 3'd0;
            next_timer = 32'd0;
          end else begin
            next_timer = timer + 32'd1;
          end
        end
      end
      ST_RECOVER: begin
        if (i_off_req) begin
          next_state = ST_OFF;
        end else if (recov_done) begin
          next_state = ST_RUN;
          next_timer = 32'd0;
        end else begin
          next_timer = timer + 32'd1;
        end
      end
      ST_LATCHED: begin
        if (i_off_req) begin
          next_state = ST_OFF;
        end
      end
      ST_OFF: begin
        // An off request clears the latch and the restart history.
        next_restart_cnt = 3'd0;
        next_timer = 32'd0;
        if (!i_off_req) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      state <= ST_RUN;
      restart_cnt <= 3'd0;
      timer <= 32'd0;
    end else if (i_clk_en) begin
      state <= next_state;
      restart_cnt <= next_restart_cnt;
      timer <= next_timer;
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_sys_rst) begin
      o_out_en <= 1'b0;
      o_latched <= 1'b0;
      o_restart_cnt <= 3'd0;
    end else if (i_clk_en) begin
      o_out_en <= (next_state == ST_RUN);
      o_latched <= (next_state == ST_LATCHED);
      o_restart_cnt <= next_restart_cnt;
    end
  end
endmodule : tifr_core

// File: dv/thermal_input_fault_response_test.sv
`timescale 1ns/1ns
module thermal_input_fault_response_test;
  import tifr_pkg::*;
  localparam int RC = 20;
  localparam int CC = 50;
  logic i_ref_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_off_req = 1'b0;
  logic i_clk_en = 1'b1;
  logic [15:0] i_temp = 16'h0019;
  logic [15:0] i_vin = 16'h00f0;
  logic [7:0] cmd;
  logic wr;
  logic rd;
  logic [15:0] wd;
  logic [15:0] o_rd_data;
  logic o_ack;
  logic o_nak;
  tifr_alarm_t o_alarm;
  logic o_out_en;
  logic o_latched;
  logic [2:0] o_restart_cnt;
  logic [17:0] q[$];
  logic [17:0] e;
  logic [31:0] seed = 32'h165ffabf;
  logic [15:0] v;
  logic [15:0] rst_v [7] = '{16'h006e, 16'h0080, 16'h0064, 16'hffd8, 16'hffd3, 16'h00b8, 16'h010e};
  logic [15:0] bad_ot [3] = '{16'h000f, 16'h0048, 16'h00f8};
  logic [15:0] bad_ut [4] = '{16'h0098, 16'h0080, 16'h0078, 16'h00c0};
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #4 i_ref_clk = ~i_ref_clk;
  tifr_host_model u_tifr_host_model (.i_ref_clk(i_ref_clk), .o_cmd_code(cmd), .o_wr_req(wr),
    .o_rd_req(rd), .o_wr_data(wd));
  tifr_core #(.P_RECOV_CYC(32'(RC)), .P_CLEAR_CYC(32'(CC))) u_tifr_core (.i_ref_clk(i_ref_clk),
    .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_cmd_code(cmd), .i_wr_req(wr), .i_wr_data(wd),
    .i_rd_req(rd), .i_temp(i_temp), .i_vin(i_vin), .i_off_req(i_off_req), .o_rd_data(o_rd_data),
    .o_ack(o_ack), .o_nak(o_nak), .o_alarm(o_alarm), .o_out_en(o_out_en),
    .o_latched(o_latched), .o_restart_cnt(o_restart_cnt));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic complete_run();
    $display("errors %0d checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [15:0] x, input logic [15:0] g);
    n_tests++;
    if (g !== x) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      num_errors++;
    end
  endtask : check
  task automatic acc(input logic r, input logic [7:0] c, input logic [15:0] d, input logic n,
    input logic [15:0] x);
    q.push_back({r, n, x});
    u_tifr_host_model.access(r, c, d);
  endtask : acc
  task automatic wt(input int n);
    repeat (n) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask : wt
  task automatic ck(input logic o, input logic l, input logic [2:0] c);
    check("out_en", {15'h0, o}, {15'h0, o_out_en});
    check("latched", {15'h0, l}, {15'h0, o_latched});
    check("restart_cnt", {13'h0, c}, {13'h0, o_restart_cnt});
  endtask : ck
  task automatic pulse(input logic [15:0] t);
    @(posedge i_ref_clk);
    i_temp <= t;
    @(posedge i_ref_clk);
    i_temp <= 16'h0019;
    @(negedge i_ref_clk);
  endtask : pulse
  task automatic al(input logic [15:0] t, input logic [15:0] u, input logic [4:0] x);
    @(posedge i_ref_clk);
    i_temp <= t;
    i_vin <= u;
    wt(2);
    check("alarm", {11'h0, x}, {11'h0, o_alarm});
  endtask : al
  task automatic off_cycle();
    @(posedge i_ref_clk);
    i_off_req <= 1'b1;
    wt(2);
    ck(1'b0, 1'b0, 3'h0);
    @(posedge i_ref_clk);
    i_off_req <= 1'b0;
    wt(3);
    ck(1'b1, 1'b0, 3'h0);
  endtask : off_cycle
  // Scoreboard: oldest noted answer against each ack or nak
  always @(posedge i_ref_clk) begin
    if (o_ack === 1'b1 || o_nak === 1'b1) begin
      e = q.pop_front();
      check("nak", {15'h0, e[16]}, {15'h0, o_nak});
      if (e[17]) check("rd_data", e[15:0], o_rd_data);
    end
  end
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (2) @(posedge i_ref_clk);
    i_sys_rst <= 1'b0;
    wt(2);
    ck(1'b1, 1'b0, 3'h0);
    foreach (rst_v[k]) acc(1'b1, 8'h4f + 8'(k), 16'h0, 1'b0, rst_v[k]);
    acc(1'b1, 8'h56, 16'h0, 1'b1, 16'h0);
    foreach (bad_ot[k]) acc(1'b0, 8'h50, bad_ot[k], 1'b0, 16'h0);
    acc(1'b1, 8'h50, 16'h0, 1'b0, 16'h0080);
    foreach (bad_ut[k]) acc(1'b0, 8'h54, bad_ut[k], 1'b0, 16'h0);
    acc(1'b1, 8'h54, 16'h0, 1'b0, 16'h00b8);
    repeat (4) begin
      seed = xs(seed);
      v = 16'(seed % 32'h9c) - 16'h002d;
      acc(1'b0, 8'h51, v, 1'b0, 16'h0);
      acc(1'b1, 8'h51, 16'h0, 1'b0, v);
    end
    acc(1'b0, 8'h51, 16'h0064, 1'b0, 16'h0);
    al(16'h0064, 16'h010e, 5'h00);
    al(16'h0065, 16'h010f, 5'h11);
    al(16'hffd8, 16'h010e, 5'h00);
    al(16'hffd7, 16'h010e, 5'h08);
    acc(1'b0, 8'h54, 16'h0000, 1'b0, 16'h0);
    al(16'hffd2, 16'h010e, 5'h0a);
    ck(1'b1, 1'b0, 3'h0);
    al(16'h0019, 16'h010e, 5'h00);
    acc(1'b0, 8'h54, 16'h00b8, 1'b0, 16'h0);
    pulse(16'hffd2);
    ck(1'b0, 1'b0, 3'h1);
    wt(RC + CC + 10);
    ck(1'b1, 1'b0, 3'h0);
    acc(1'b0, 8'h50, 16'h008f, 1'b0, 16'h0);
    pulse(16'h006f);
    ck(1'b0, 1'b0, 3'h1);
    wt(RC - 3);
    ck(1'b0, 1'b0, 3'h1);
    wt(6);
    ck(1'b1, 1'b0, 3'h1);
    pulse(16'h006f);
    wt(30);
    ck(1'b0, 1'b1, 3'h1);
    off_cycle();
    acc(1'b0, 8'h50, 16'h0080, 1'b0, 16'h0);
    pulse(16'h006f);
    ck(1'b0, 1'b1, 3'h0);
    off_cycle();
    acc(1'b0, 8'h50, 16'h00b8, 1'b0, 16'h0);
    for (int k = 1; k < 4; k++) begin
      pulse(16'h006f);
      ck(1'b0, 1'b0, 3'(k));
      wt(RC + 3);
    end
    // Clock enable low must freeze the recovery timer and the out_en, latched and restart_cnt outputs
    pulse(16'h006f);
    check("alarm", 16'h0014, {11'h0, o_alarm});
    ck(1'b0, 1'b0, 3'h4);
    @(posedge i_ref_clk);
    i_clk_en <= 1'b0;
    wt(RC + 5);
    ck(1'b0, 1'b0, 3'h4);
    @(posedge i_ref_clk);
    i_clk_en <= 1'b1;
    wt(RC - 3);
    ck(1'b0, 1'b0, 3'h4);
    wt(3);
    ck(1'b1, 1'b0, 3'h4);
    off_cycle();
    complete_run();
  end
endmodule : thermal_input_fault_response_test

// File: dv/tifr_core_assertions.sv
`timescale 1ns/1ns
module tifr_core_assertions #(
  parameter logic [31:0] P_RECOV_CYC = 32'h14,
  parameter logic [31:0] P_CLEAR_CYC = 32'h32
) (
  input wire logic i_ref_clk,
  input wire logic i_sys_rst,
  input wire logic i_clk_en,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_wr_req,
  input wire logic i_rd_req,
  input wire logic i_off_req,
  input wire logic o_ack,
  input wire logic o_nak,
  input wire tifr_pkg::tifr_alarm_t o_alarm,
  input wire logic o_out_en,
  input wire logic o_latched,
  input wire logic [2:0] o_restart_cnt
);
  import tifr_pkg::*;
  logic [31:0] low_n;
  logic [31:0] run_n;
  wire req = i_clk_en && (i_wr_req || i_rd_req);
  // Counters stand still while the clock enable is low, as the design's timer does
  always_ff @(posedge i_ref_clk) begin
    low_n <= (i_sys_rst || o_out_en) ? 32'h0 : (i_clk_en ? low_n + 32'h1 : low_n);
    run_n <= (i_sys_rst || !o_out_en || o_restart_cnt == 3'h0) ? 32'h0 :
             (i_clk_en ? run_n + 32'h1 : run_n);
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  chk_ack_decode: assert property (req |=> (o_ack != o_nak) &&
    (o_nak == !($past(i_cmd_code) inside {[8'h4f:8'h55]}))) else $error("bad access answer");
  chk_no_answer: assert property (!req |=> !o_ack && !o_nak) else $error("unasked answer");
  chk_hot_stop: assert property ($rose(o_alarm.ot_fault) |-> !o_out_en)
    else $error("hot fault kept output on");
  chk_recover_time: assert property ($rose(o_out_en) && o_restart_cnt != 3'h0 |->
    low_n >= P_RECOV_CYC - 1 && low_n <= P_RECOV_CYC + 1) else $error("recovery delay wrong");
  chk_latch_hold: assert property (o_latched && !i_off_req |=> o_latched && !o_out_en)
    else $error("latched state left");
  chk_off_stops: assert property (i_off_req |=> !o_out_en) else $error("off ignored");
  chk_cnt_step: assert property ($changed(o_restart_cnt) |-> o_restart_cnt == 3'h0 ||
    o_restart_cnt == $past(o_restart_cnt) + 3'h1) else $error("restart count jumped");
  chk_cnt_clear: assert property (run_n <= P_CLEAR_CYC + 1) else $error("count not cleared");
  cov_latch: cover property ($rose(o_latched));
  cov_restart: cover property ($rose(o_out_en) && o_restart_cnt != 3'h0);
  cov_nak: cover property (o_nak);
endmodule : tifr_core_assertions
bind tifr_core tifr_core_assertions #(.P_RECOV_CYC(P_RECOV_CYC), .P_CLEAR_CYC(P_CLEAR_CYC)) u_chk (
  .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_cmd_code(i_cmd_code),
  .i_wr_req(i_wr_req), .i_rd_req(i_rd_req), .i_off_req(i_off_req), .o_ack(o_ack),
  .o_nak(o_nak), .o_alarm(o_alarm), .o_out_en(o_out_en), .o_latched(o_latched),
  .o_restart_cnt(o_restart_cnt));

// File: dv/tifr_host_model.sv
`timescale 1ns/1ns
module tifr_host_model (
  input wire logic i_ref_clk,
  output logic [7:0] o_cmd_code = 8'h00,
  output logic o_wr_req = 1'b0,
  output logic o_rd_req = 1'b0,
  output logic [15:0] o_wr_data = 16'h0000
);
  // One strobe pulse, then wait out the answer before the next access
  task automatic access(input logic r, input logic [7:0] c, input logic [15:0] d);
    @(posedge i_ref_clk);
    o_cmd_code <= c;
    o_wr_data <= d;
    o_wr_req <= !r;
    o_rd_req <= r;
    @(posedge i_ref_clk);
    o_wr_req <= 1'b0;
    o_rd_req <= 1'b0;
    @(posedge i_ref_clk);
    // Stale data is inverted so it never looks like a valid word
    o_wr_data <= ~d;
    o_cmd_code <= ~c;
  endtask : access
endmodule : tifr_host_model
